// ---- shared/scfg_pkg.sv ----
// Package: constants, states and carriers of the configuration target port
`default_nettype none
package scfg_pkg;
  // ==========================================================
  // Bus framing
  // ==========================================================
  // 8-bit write address D2h, so the 7-bit target address is 69h
  localparam logic [6:0] TGT_ADDR     = 7'h69;
  localparam logic [3:0] BITS_BYTE    = 4'h8;
  localparam logic [2:0] LAST_TX_BIT  = 3'h7;
  localparam int         CMD_MODE_BIT = 7;
  localparam int         CMD_CS_MSB   = 6;
  localparam int         CMD_CS_LSB   = 5;
  localparam logic [1:0] CS_SELF      = 2'h0;
  localparam int         CMD_OFS_MSB  = 4;
  localparam logic [4:0] BLOCK_START  = 5'h00;
  // ==========================================================
  // Register file
  // ==========================================================
  localparam int         NUM_REGS     = 8;
  localparam logic [7:0] BLOCK_COUNT  = 8'h08;
  localparam logic [4:0] LAST_OFS     = 5'h07;
  // Byte i sits at bits [8i+7:8i]; byte 7 default comes from a parameter
  localparam logic [63:0] REG_DEFAULT = 64'h0013_0001_AFEA_007C;
  localparam logic [63:0] REG_WMASK   = 64'h00C0_0000_0084_0004;
  localparam int         OE_BYTE      = 0;
  localparam int         OE_BIT       = 2;
  localparam int         SPREAD_BYTE  = 2;
  localparam int         SPREAD_BIT   = 2;
  localparam int         DEPTH_BIT    = 7;
  localparam int         TEST_BYTE    = 6;
  localparam int         TMODE_BIT    = 6;
  localparam int         TSEL_BIT     = 7;
  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD      = 4'h2,
    ST_CMD_ACK  = 4'h6,
    ST_WR       = 4'h7,
    ST_WR_ACK   = 4'h5,
    ST_RD       = 4'h4,
    ST_RD_ACK   = 4'hC,
    ST_IGNORE   = 4'hD
  } scfg_state_t;

  typedef struct packed {
    logic [4:0] ofs;
    logic [7:0] data;
  } scfg_wr_t;
endpackage : scfg_pkg
`default_nettype wire

// ---- rtl/scfg_target.sv ----
// Module: two-wire configuration target with register file and write buffer
`default_nettype none
// ============================================================
// Overview of operation
// [R01] Acknowledge only address byte D2h for write, D3h for read.
// [R02] Command bit 7 low picks block transfer, high picks single byte.
// [R03] Host puts 00 in command bits 6:5 to select this device.
// [R04] Command bits 4:0 give single-byte offset; zero for block transfers.
// [R05] Block transfers walk offsets upward, each byte most significant bit first.
// [R06] Block transfer may stop after any byte; completed bytes are kept.
// [R07] Start, address with write, ack, command, ack open every transaction.
// [R08] Block write: count byte then data bytes, each acknowledged, then stop.
// [R09] Block read: after repeated start and read address, send count then data.
// [R10] Host acknowledges read bytes, not-acknowledges the last one.
// [R11] Single write: one data byte acknowledged and stored at command offset.
// [R12] Single read: repeated start, read address, one byte from the offset.
// [R13] All registers load their defaults at reset; no access needed.
// [R14] Host changes registers at initialization, not for power management.
// [R15] Reads work at bus clocks up to 400 kHz.
// [R16] Registers switch spreading on or off and pick its depth.
// [R17] Output buffer enable is set separately through the bus.
// [R18] Byte 0 bit 2 enables the differential output, default one.
// [R19] Byte 2 bit 2 spread on, default 0; bit 7 depth, default 1.
// [R20] Byte 6 bit 6 test clock mode; bit 7 picks hi-Z or divided reference.
// [R21] Foreign address or nonzero chip select: no ack, line released.
// [R22] Reserved bits read their defaults; writes to them are ignored.
// ============================================================
module scfg_target #(
  parameter int         DEPTH   = 2,
  parameter logic [7:0] ID_CODE = 8'h5A   // Arbitrary identification value
) (
  // Clock, reset, enable
  input  wire logic clock_in,
  input  wire logic rstn_in,
  input  wire logic en_in,
  // Serial bus pins
  input  wire logic scl_in,
  output logic      scl_out,
  output logic      scl_oe_out,
  input  wire logic serial_data_pin_in,
  output logic      serial_data_pin_out,
  output logic      serial_data_pin_oe_out,
  // Register update pacing
  input  wire logic cfg_ready_in,
  // Configuration outputs
  output logic      diff_out_enable_out,
  output logic      spread_enable_bit_out,
  output logic      spread_depth_select_out,
  output logic      test_mode_out,
  output logic      test_sel_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ==========================================================
  // Pin edge and condition detect
  // ==========================================================
  logic scl_q;
  logic sda_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (en_in) begin
      scl_q <= scl_in;
      sda_q <= serial_data_pin_in;
    end
  end

  // 20 MHz sampling leaves ample margin at 400 kHz
  assign rise  = scl_in & ~scl_q;                                // see [R15]
  assign fall  = ~scl_in & scl_q;
  assign start = scl_in & scl_q & sda_q & ~serial_data_pin_in;   // see [R07]
  assign stop  = scl_in & scl_q & ~sda_q & serial_data_pin_in;   // see [R06]

  // ==========================================================
  // Write buffer
  // ==========================================================
  scfg_pkg::scfg_wr_t mem_q [DEPTH];
  scfg_pkg::scfg_wr_t mem_d [DEPTH];
  scfg_pkg::scfg_wr_t pw_q;
  logic [AW-1:0]      wp_q;
  logic [AW-1:0]      wp_d;
  logic [AW-1:0]      rp_q;
  logic [AW-1:0]      rp_d;
  logic [CW-1:0]      cnt_q;
  logic [CW-1:0]      cnt_d;
  logic               push;
  logic               pop;
  logic               in_ready;
  logic               out_valid;
  scfg_pkg::scfg_wr_t out_word;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_word  = mem_q[rp_q];
  assign pop       = out_valid & cfg_ready_in;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = pw_q;
      wp_d        = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_q <= '{default: '0};
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (en_in) begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Register file
  // ==========================================================
  logic [7:0] regs_q [scfg_pkg::NUM_REGS];
  logic [7:0] regs_d [scfg_pkg::NUM_REGS];

  for (genvar i = 0; i < scfg_pkg::NUM_REGS; i++) begin : g_reg
    localparam logic [7:0] MASK = scfg_pkg::REG_WMASK[8*i +: 8];
    localparam logic [7:0] DEFV = (i == scfg_pkg::NUM_REGS - 1) ?
                                  ID_CODE : scfg_pkg::REG_DEFAULT[8*i +: 8];
    always_comb begin
      regs_d[i] = regs_q[i];
      if (pop && out_word.ofs == 5'(i)) begin
        regs_d[i] = (regs_q[i] & ~MASK) | (out_word.data & MASK);   // see [R22]
      end
    end
    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        regs_q[i] <= DEFV;                                          // see [R13]
      end else if (en_in) begin
        regs_q[i] <= regs_d[i];
      end
    end
    reserved_fixed_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // see [R22]
      (regs_q[i] & ~MASK) == (DEFV & ~MASK))
      else $error("reserved register bits changed");
  end

  assign diff_out_enable_out     = regs_q[scfg_pkg::OE_BYTE][scfg_pkg::OE_BIT];    // see [R18]
  // Spread switch and depth share one byte
  assign spread_enable_bit_out   =
    regs_q[scfg_pkg::SPREAD_BYTE][scfg_pkg::SPREAD_BIT];                    // see [R16]
  assign spread_depth_select_out =
    regs_q[scfg_pkg::SPREAD_BYTE][scfg_pkg::DEPTH_BIT];                     // see [R19]
  assign test_mode_out           = regs_q[scfg_pkg::TEST_BYTE][scfg_pkg::TMODE_BIT]; // see [R20]
  assign test_sel_out            = regs_q[scfg_pkg::TEST_BYTE][scfg_pkg::TSEL_BIT];

  // ==========================================================
  // Protocol engine
  // ==========================================================
  scfg_pkg::scfg_state_t st_q;
  scfg_pkg::scfg_state_t st_d;
  logic [7:0]            sh_q;
  logic [7:0]            sh_d;
  logic [7:0]            tx_q;
  logic [7:0]            tx_d;
  logic [3:0]            bc_q;
  logic [3:0]            bc_d;
  logic [4:0]            idx_q;
  logic [4:0]            idx_d;
  logic                  rd_q;
  logic                  rd_d;
  logic                  single_q;
  logic                  single_d;
  logic                  first_q;
  logic                  first_d;
  logic                  oe_q;
  logic                  oe_d;
  logic                  pend_q;
  logic                  pend_d;
  scfg_pkg::scfg_wr_t    pw_d;
  logic                  rx_state;
  logic                  rx_done;
  logic                  count_turn;
  logic [7:0]            rd_byte;
  logic [7:0]            load_byte;

  assign rx_state   = (st_q == scfg_pkg::ST_ADDR) || (st_q == scfg_pkg::ST_CMD) ||
                      (st_q == scfg_pkg::ST_WR);
  assign rx_done    = rx_state & fall & (bc_q == scfg_pkg::BITS_BYTE);
  assign count_turn = ~single_q & first_q;
  assign rd_byte    = (idx_q <= scfg_pkg::LAST_OFS) ? regs_q[idx_q[2:0]] : 8'h00;
  assign load_byte  = count_turn ? scfg_pkg::BLOCK_COUNT : rd_byte;  // see [R09]

  always_comb begin
    st_d     = st_q;
    sh_d     = sh_q;
    tx_d     = tx_q;
    bc_d     = bc_q;
    idx_d    = idx_q;
    rd_d     = rd_q;
    single_d = single_q;
    first_d  = first_q;
    oe_d     = oe_q;
    pend_d   = pend_q;
    pw_d     = pw_q;
    push     = 1'b0;
    // A finished byte is kept even if stop follows at once
    if (pend_q && in_ready) begin
      push   = 1'b1;                                                  // see [R06]
      pend_d = 1'b0;
    end
    if (rx_state && rise && bc_q != scfg_pkg::BITS_BYTE) begin
      sh_d = {sh_q[6:0], serial_data_pin_in};                         // see [R05]
      bc_d = bc_q + 1'b1;
    end
    if (stop) begin
      st_d = scfg_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d = scfg_pkg::ST_ADDR;                                       // see [R07]
      bc_d = '0;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        scfg_pkg::ST_ADDR: begin
          if (rx_done) begin
            if (sh_q[7:1] == scfg_pkg::TGT_ADDR) begin                // see [R01]
              oe_d = 1'b1;
              rd_d = sh_q[0];
              st_d = scfg_pkg::ST_ADDR_ACK;
            end else begin
              st_d = scfg_pkg::ST_IGNORE;                             // see [R21]
            end
          end
        end
        scfg_pkg::ST_CMD: begin
          if (rx_done) begin
            if (sh_q[scfg_pkg::CMD_CS_MSB:scfg_pkg::CMD_CS_LSB] != scfg_pkg::CS_SELF) begin
              st_d = scfg_pkg::ST_IGNORE;                             // see [R21]
            end else begin
              oe_d     = 1'b1;
              single_d = sh_q[scfg_pkg::CMD_MODE_BIT];                // see [R02]
              idx_d    = sh_q[scfg_pkg::CMD_MODE_BIT] ?
                         sh_q[scfg_pkg::CMD_OFS_MSB:0] : scfg_pkg::BLOCK_START; // see [R04]
              first_d  = ~sh_q[scfg_pkg::CMD_MODE_BIT];
              st_d     = scfg_pkg::ST_CMD_ACK;
            end
          end
        end
        scfg_pkg::ST_WR: begin
          if (rx_done) begin
            oe_d    = 1'b1;                                           // see [R08]
            st_d    = scfg_pkg::ST_WR_ACK;
            first_d = 1'b0;
            if (!count_turn) begin
              pw_d   = '{ofs: idx_q, data: sh_q};                     // see [R11]
              pend_d = 1'b1;
              idx_d  = idx_q + 1'b1;
            end
          end
        end
        scfg_pkg::ST_ADDR_ACK: begin
          if (fall) begin
            bc_d = '0;
            if (rd_q) begin
              st_d    = scfg_pkg::ST_RD;                              // see [R12]
              tx_d    = load_byte;
              oe_d    = ~load_byte[7];
              first_d = 1'b0;
              if (!count_turn) begin
                idx_d = idx_q + 1'b1;
              end
            end else begin
              st_d = scfg_pkg::ST_CMD;
              oe_d = 1'b0;
            end
          end
        end
        scfg_pkg::ST_CMD_ACK,
        scfg_pkg::ST_WR_ACK: begin
          if (fall) begin
            oe_d = 1'b0;
            bc_d = '0;
            st_d = scfg_pkg::ST_WR;
          end
        end
        scfg_pkg::ST_RD: begin
          if (fall) begin
            if (bc_q[2:0] == scfg_pkg::LAST_TX_BIT) begin
              oe_d = 1'b0;
              st_d = scfg_pkg::ST_RD_ACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};                               // see [R05]
              oe_d = ~tx_q[6];
              bc_d = bc_q + 1'b1;
            end
          end
        end
        scfg_pkg::ST_RD_ACK: begin
          if (rise && serial_data_pin_in) begin
            st_d = scfg_pkg::ST_IGNORE;                               // see [R10]
          end else if (fall) begin
            st_d = scfg_pkg::ST_RD;
            tx_d = rd_byte;
            oe_d = ~rd_byte[7];
            bc_d = '0;
            idx_d = idx_q + 1'b1;
          end
        end
        scfg_pkg::ST_IDLE,
        scfg_pkg::ST_IGNORE: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = scfg_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q     <= scfg_pkg::ST_IDLE;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      bc_q     <= 4'h0;
      idx_q    <= 5'h00;
      rd_q     <= 1'b0;
      single_q <= 1'b0;
      first_q  <= 1'b0;
      oe_q     <= 1'b0;
      pend_q   <= 1'b0;
      pw_q     <= '0;
    end else if (en_in) begin
      st_q     <= st_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      bc_q     <= bc_d;
      idx_q    <= idx_d;
      rd_q     <= rd_d;
      single_q <= single_d;
      first_q  <= first_d;
      oe_q     <= oe_d;
      pend_q   <= pend_d;
      pw_q     <= pw_d;
    end
  end

  // Open-drain pins only ever pull low
  assign serial_data_pin_out    = 1'b0;
  assign serial_data_pin_oe_out = oe_q;
  assign scl_out                = 1'b0;
  // Stretch the ack low phase while the buffer is full
  assign scl_oe_out             = pend_q & ~in_ready;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  foreign_addr_a: assert property ( // see [R01]
    en_in && st_q == scfg_pkg::ST_ADDR && rx_done && !start && !stop &&
    sh_q[7:1] != scfg_pkg::TGT_ADDR |=> st_q == scfg_pkg::ST_IGNORE && !oe_q)
    else $error("foreign address was acknowledged");
  addr_ack_a: assert property ( // see [R07]
    en_in && st_q == scfg_pkg::ST_ADDR && rx_done && !start && !stop &&
    sh_q[7:1] == scfg_pkg::TGT_ADDR |=> oe_q && rd_q == $past(sh_q[0]))
    else $error("own address not acknowledged");
  chip_select_a: assert property ( // see [R21]
    st_q == scfg_pkg::ST_IGNORE |-> !serial_data_pin_oe_out)
    else $error("data line driven while ignoring");
  single_index_a: assert property ( // see [R04]
    en_in && st_q == scfg_pkg::ST_CMD && rx_done && !start && !stop &&
    sh_q[7:5] == 3'h4 |=> single_q && idx_q == $past(sh_q[4:0]))
    else $error("single offset not taken from command");
  block_index_a: assert property ( // see [R02]
    en_in && st_q == scfg_pkg::ST_CMD && rx_done && !start && !stop &&
    sh_q[7:5] == 3'h0 |=> !single_q && first_q && idx_q == 5'h00)
    else $error("block transfer not started at offset zero");
  count_first_a: assert property ( // see [R09]
    en_in && st_q == scfg_pkg::ST_ADDR_ACK && fall && rd_q && count_turn &&
    !start && !stop |=> tx_q == scfg_pkg::BLOCK_COUNT && oe_q == !scfg_pkg::BLOCK_COUNT[7])
    else $error("block read did not open with the count");
  msb_first_a: assert property ( // see [R05]
    st_q == scfg_pkg::ST_RD |-> oe_q == ~tx_q[7])
    else $error("read bit does not match shifted byte");
  stop_idle_a: assert property ( // see [R06]
    en_in && stop |=> st_q == scfg_pkg::ST_IDLE && !oe_q)
    else $error("stop did not end the transaction");
  oe_write_a: assert property ( // see [R17]
    en_in && pop && out_word.ofs == 5'h00 |=>
    diff_out_enable_out == $past(out_word.data[scfg_pkg::OE_BIT]))
    else $error("output enable not updated by write");
  spread_write_a: assert property ( // see [R16]
    en_in && pop && out_word.ofs == 5'h02 |=>
    spread_enable_bit_out == $past(out_word.data[2]) &&
    spread_depth_select_out == $past(out_word.data[7]))
    else $error("spread settings not updated by write");
  keep_byte_a: assert property ( // see [R08]
    en_in && st_q == scfg_pkg::ST_WR && rx_done && !count_turn && !start &&
    !stop |=> pend_q && pw_q.data == $past(sh_q))
    else $error("received data byte was not queued");
endmodule : scfg_target
`default_nettype wire

// ---- testbench/scfg_host_model.sv ----
// Host controller model for the two-wire configuration bus
`default_nettype none
module scfg_host_model #(
  parameter int HALF  = 25,
  parameter int LIMIT = 4000
) (
  // Clock
  input  wire logic       clock_in,
  // Wire levels after pull-ups
  input  wire logic       scl_wire_in,
  input  wire logic       sda_wire_in,
  // Open-drain pulls, high pulls low
  output logic            scl_low_out,
  output logic            sda_low_out,
  // Stretch waits that ran out
  output logic [7:0]      timeouts_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_low_out  = 1'b0;
    sda_low_out  = 1'b0;
    timeouts_out = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : idle
  // Target may hold SCL low, so the high phase waits for the wire
  task automatic rise_scl();
    int k;
    k = 0;
    @(posedge clock_in);
    scl_low_out <= 1'b0;
    do begin
      @(negedge clock_in);
      k++;
    end while (!scl_wire_in && k < LIMIT);
    if (!scl_wire_in) timeouts_out <= timeouts_out + 8'h01;
    idle(HALF);
  endtask : rise_scl
  // Data changes only while SCL is low
  task automatic bit_io(input logic drive, output logic seen);
    @(posedge clock_in);
    sda_low_out <= ~drive;
    idle(HALF);
    rise_scl();
    @(negedge clock_in);
    seen = sda_wire_in;
    @(posedge clock_in);
    scl_low_out <= 1'b1;
  endtask : bit_io
  // Start or repeated start; set-up use only, no power management
  task automatic frame_start();
    @(posedge clock_in);
    sda_low_out <= 1'b0;
    idle(HALF);
    rise_scl();
    @(posedge clock_in);
    sda_low_out <= 1'b1;
    idle(HALF);
    scl_low_out <= 1'b1;
  endtask : frame_start
  task automatic frame_stop();
    @(posedge clock_in);
    sda_low_out <= 1'b1;
    idle(HALF);
    rise_scl();
    @(posedge clock_in);
    sda_low_out <= 1'b0;
    idle(HALF);
  endtask : frame_stop
  // Most significant bit first, then the target's acknowledge
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put_byte
  // Acknowledge all but the last byte read
  task automatic get_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(~ack, s);
  endtask : get_byte
endmodule : scfg_host_model
`default_nettype wire

// ---- testbench/smbus_config_target_port_test.sv ----
// Self-checking bench for the two-wire configuration target
`default_nettype none
module smbus_config_target_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  ID_VAL = 8'h3C;  // Arbitrary value
  localparam logic [63:0] DEFS   = {ID_VAL, 56'h13_0001_AFEA_007C};
  logic       clk = 1'b0, rstn = 1'b0, cfg_ready = 1'b1;
  logic       scl_low, sda_low, scl_oe, sda_oe, scl_drv, sda_drv;
  logic       diff, spread, depth, tmode, tsel, a1, a2, a3;
  logic       watch = 1'b0, quiet_hit = 1'b0;
  logic [3:0] wa;
  logic [7:0] timeouts, rd;
  wire        scl_wire, sda_wire;
  int         bad_count = 0, tests_run = 0;
  // Open drain with pull-ups: any party pulling low wins
  assign scl_wire = ~scl_low & (scl_oe ? scl_drv : 1'b1);
  assign sda_wire = ~sda_low & (sda_oe ? sda_drv : 1'b1);
  always #25 clk = ~clk;
  always @(negedge clk) if (watch && sda_oe) quiet_hit <= 1'b1;
  scfg_target #(.DEPTH(2), .ID_CODE(ID_VAL)) u_dut (
    .clock_in(clk), .rstn_in(rstn), .en_in(1'b1),
    .scl_in(scl_wire), .scl_out(scl_drv), .scl_oe_out(scl_oe),
    .serial_data_pin_in(sda_wire), .serial_data_pin_out(sda_drv),
    .serial_data_pin_oe_out(sda_oe), .cfg_ready_in(cfg_ready),
    .diff_out_enable_out(diff), .spread_enable_bit_out(spread),
    .spread_depth_select_out(depth), .test_mode_out(tmode), .test_sel_out(tsel));
  scfg_host_model #(.HALF(25), .LIMIT(4000)) u_host (
    .clock_in(clk), .scl_wire_in(scl_wire), .sda_wire_in(sda_wire),
    .scl_low_out(scl_low), .sda_low_out(sda_low), .timeouts_out(timeouts));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic open_cmd(input logic [7:0] cmd, output logic ack_a, output logic ack_c);
    u_host.frame_start();
    u_host.put_byte(8'hD2, ack_a);
    u_host.put_byte(cmd, ack_c);
  endtask : open_cmd
  task automatic byte_write(input logic [4:0] ofs, input logic [7:0] v);
    logic a, c, d;
    open_cmd({3'b100, ofs}, a, c);
    u_host.put_byte(v, d);
    u_host.frame_stop();
    check("write acks", {5'h00, a, c, d}, 8'h07);
  endtask : byte_write
  task automatic byte_read(input logic [4:0] ofs, output logic [7:0] v);
    logic a, c, d;
    open_cmd({3'b100, ofs}, a, c);
    u_host.frame_start();
    u_host.put_byte(8'hD3, d);
    u_host.get_byte(1'b0, v);
    u_host.frame_stop();
    check("read acks", {5'h00, a, c, d}, 8'h07);
  endtask : byte_read
  // Block read stopped after n data bytes
  task automatic block_read(input int n, input logic [63:0] exp);
    logic a, c, d;
    logic [7:0] v;
    open_cmd(8'h00, a, c);
    u_host.frame_start();
    u_host.put_byte(8'hD3, d);
    u_host.get_byte(1'b1, v);
    check("block count", v, 8'h08);
    for (int i = 0; i < n; i++) begin
      u_host.get_byte(i < n - 1, v);
      check($sformatf("block byte %0d", i), v, exp[8*i+:8]);
    end
    u_host.frame_stop();
    check("block acks", {5'h00, a, c, d}, 8'h07);
  endtask : block_read
  // Buffer full: SCL held low until the register side drains
  task automatic hold_then_drain();
    int k;
    k = 0;
    while (scl_oe !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    repeat (100) @(negedge clk);
    check("stretch held", {5'h00, scl_oe, spread, diff}, 8'h04);
    @(posedge clk);
    cfg_ready <= 1'b1;
  endtask : hold_then_drain
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    @(negedge clk);
    check("reset outputs", {1'b0, scl_oe, sda_oe, diff, spread, depth, tmode, tsel},
          8'h14);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    block_read(8, DEFS);
    watch <= 1'b1;
    u_host.frame_start();
    u_host.put_byte(8'hD4, a1);
    u_host.put_byte(8'hFF, a2);
    u_host.frame_stop();
    watch <= 1'b0;
    check("foreign address", {6'h00, a1, quiet_hit}, 8'h00);
    open_cmd(8'hA0, a1, a2);
    u_host.put_byte(8'h00, a3);
    u_host.frame_stop();
    @(negedge clk);
    check("chip select", {4'h0, a1, a2, a3, diff}, 8'h09);
    byte_write(5'h00, 8'h00);
    repeat (4) @(negedge clk);
    check("output off", {7'h00, diff}, 8'h00);
    byte_read(5'h00, rd);
    check("byte 0", rd, 8'h78);
    @(posedge clk);
    cfg_ready <= 1'b0;
    fork
      begin
        open_cmd(8'h00, wa[3], wa[2]);
        u_host.put_byte(8'h03, wa[1]);
        u_host.put_byte(8'hFF, wa[0]);
        u_host.put_byte(8'hFF, a1);
        u_host.put_byte(8'h04, a2);
        u_host.frame_stop();
      end
      hold_then_drain();
    join
    repeat (4) @(negedge clk);
    check("block write acks", {2'h0, wa, a1, a2}, 8'h3F);
    check("spread outputs", {5'h00, diff, spread, depth}, 8'h06);
    byte_write(5'h06, 8'hC0);
    repeat (4) @(negedge clk);
    check("test outputs", {6'h00, tmode, tsel}, 8'h03);
    byte_read(5'h06, rd);
    check("byte 6", rd, 8'hD3);
    block_read(3, 64'h0000_0000_006E_007C);
    check("stretch timeouts", timeouts, 8'h00);
    wrap_up();
  end
endmodule : smbus_config_target_port_test
`default_nettype wire
